/* core/bst_pkg.sv */
// Shared constants, state codes and state carriers of the boundary-scan test port.
package bst_pkg;

  // Register lengths.
  localparam int BSR_LEN = 98;
  localparam int BSR_IN_W = 49;
  localparam int BSR_OUT_W = BSR_LEN - BSR_IN_W;
  localparam int IR_W = 3;
  localparam int ID_W = 32;

  // Instruction codes.
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h6;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  // Fixed pattern loaded into the instruction shifter in Capture-IR.
  localparam logic [IR_W-1:0] IR_CAPT_VAL = 3'h1;

  // Identification word field positions.
  localparam int ID_PROD_LSB = 1;
  localparam int ID_PART_LSB = 12;
  localparam int ID_REV_LSB = 28;

  // Rising test-clock edges with mode-select high that always reach reset.
  localparam int TMS_RESET_EDGES = 5;

  // Controller states, one-hot.
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bst_state_e;

  // State clocked on the rising test-clock edge.
  typedef struct packed {
    bst_state_e st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] instr;
    logic [BSR_LEN-1:0] pin_scan_chain;
    logic [ID_W-1:0] id_sh;
    logic byp;
    logic rst_s1;
    logic rst_s2;
    logic [BSR_LEN-1:0] pin_s1;
    logic [BSR_LEN-1:0] pin_s2;
  } bst_rise_s;

  // State clocked on the falling test-clock edge.
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
    logic [BSR_OUT_W-1:0] upd;
    logic upd_tgl;
  } bst_fall_s;

  // State clocked on the system clock.
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic [BSR_OUT_W-1:0] shadow;
    logic [BSR_OUT_W-1:0] pin_out;
  } bst_sys_s;

endpackage

/* core/bst_port.sv */
// Boundary-scan test access port with controller, data registers and pin muxing.
`timescale 1ns/1ps
module bst_port import bst_pkg::*; #(
  parameter logic [10:0] PRODUCER = 11'h2A5,  // Arbitrary value.
  parameter logic [15:0] PART = 16'h1234,  // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1  // Arbitrary value.
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic [BSR_IN_W-1:0] i_pin_in,
  input wire logic [BSR_OUT_W-1:0] i_core_out,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic [BSR_OUT_W-1:0] o_pin_out
);

  // Identification word with the fixed one in bit 0.
  localparam logic [ID_W-1:0] ID_VALUE = (ID_W'(REVISION) << ID_REV_LSB)
    | (ID_W'(PART) << ID_PART_LSB) | (ID_W'(PRODUCER) << ID_PROD_LSB) | 32'h1;

  bst_rise_s rr_r;  // Rising-edge test-clock state.
  bst_rise_s rr_nxt;  // Its next value.
  bst_fall_s fr_r;  // Falling-edge test-clock state.
  bst_fall_s fr_nxt;  // Its next value.
  bst_sys_s sr_r;  // System-clock state.
  bst_sys_s sr_nxt;  // Its next value.

  // Controller next state from the mode-select value on a rising edge.
  function automatic bst_state_e tap_next(input bst_state_e s, input logic tms);
    case (s)
      ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
      default: tap_next = ST_TLR;
    endcase
  endfunction

  // True when the instruction routes the pin chain between the serial pins.
  function automatic logic bsr_sel(input logic [IR_W-1:0] ins);
    bsr_sel = (ins == INS_EXTEST) || (ins == INS_SAMPLE);
  endfunction

  // Rising-edge logic: controller, shifters and synchronisers.
  always_comb begin
    rr_nxt = rr_r;
    // The first synchroniser stages feed only the second stages.
    rr_nxt.rst_s1 = i_reset;
    rr_nxt.rst_s2 = rr_r.rst_s1;
    rr_nxt.pin_s1 = {o_pin_out, i_pin_in};
    rr_nxt.pin_s2 = rr_r.pin_s1;
    rr_nxt.st = tap_next(rr_r.st, i_tms);
    if (rr_r.rst_s2) begin
      // Power-up reset; five high mode-select edges reach the same state.
      rr_nxt.st = ST_TLR;
      rr_nxt.instr = INS_IDCODE;
      // Shifters start known, so the hold checks never compare unknowns.
      rr_nxt.ir_sh = '0;
      rr_nxt.pin_scan_chain = '0;
      rr_nxt.id_sh = '0;
      rr_nxt.byp = 1'b0;
    end else begin
      case (rr_r.st)
        ST_TLR: begin
          // Back to the identification instruction and normal pin paths.
          rr_nxt.instr = INS_IDCODE;
        end
        ST_CAP_IR: begin
          rr_nxt.ir_sh = IR_CAPT_VAL;
        end
        ST_SH_IR: begin
          // New bits enter at the top so the first bit ends in bit 0.
          rr_nxt.ir_sh = {i_tdi, rr_r.ir_sh[IR_W-1:1]};
        end
        ST_UPD_IR: begin
          rr_nxt.instr = rr_r.ir_sh;
        end
        ST_CAP_DR: begin
          if (bsr_sel(rr_r.instr)) begin
            // Inputs and the driven outputs enter the chain under both sample and external test.
            rr_nxt.pin_scan_chain = rr_r.pin_s2;
          end else if (rr_r.instr == INS_IDCODE) begin
            rr_nxt.id_sh = ID_VALUE;
          end else begin
            rr_nxt.byp = 1'b0;
          end
        end
        ST_SH_DR: begin
          // One stage per rising test-clock edge.
          if (bsr_sel(rr_r.instr)) begin
            rr_nxt.pin_scan_chain = {i_tdi, rr_r.pin_scan_chain[BSR_LEN-1:1]};
          end else if (rr_r.instr == INS_IDCODE) begin
            rr_nxt.id_sh = {i_tdi, rr_r.id_sh[ID_W-1:1]};
          end else begin
            // Undefined codes fall back to the one-bit path as bypass does.
            rr_nxt.byp = i_tdi;
          end
        end
        default: begin
          rr_nxt.instr = rr_r.instr;
        end
      endcase
    end
  end

  // Rising-edge register.
  always_ff @(posedge i_tck) begin
    rr_r <= rr_nxt;
  end

  // Falling-edge logic: serial output and the latched pin pattern.
  always_comb begin
    fr_nxt = fr_r;
    // Driving on the falling edge gives the tester half a period of setup.
    fr_nxt.tdo_oe = (rr_r.st == ST_SH_DR) || (rr_r.st == ST_SH_IR);
    if (rr_r.st == ST_SH_IR) begin
      fr_nxt.tdo = rr_r.ir_sh[0];
    end else if (rr_r.st == ST_SH_DR) begin
      if (bsr_sel(rr_r.instr)) begin
        fr_nxt.tdo = rr_r.pin_scan_chain[0];
      end else if (rr_r.instr == INS_IDCODE) begin
        fr_nxt.tdo = rr_r.id_sh[0];
      end else begin
        fr_nxt.tdo = rr_r.byp;
      end
    end else begin
      fr_nxt.tdo = 1'b0;
    end
    if (rr_r.rst_s2) begin
      fr_nxt.upd = '0;
      fr_nxt.upd_tgl = 1'b0;
      fr_nxt.tdo_oe = 1'b0;
    end else if ((rr_r.st == ST_UPD_DR) && bsr_sel(rr_r.instr)) begin
      // Outside reset the latch only changes here, so shifting never disturbs the pins.
      fr_nxt.upd = rr_r.pin_scan_chain[BSR_LEN-1:BSR_IN_W];
      fr_nxt.upd_tgl = ~fr_r.upd_tgl;
    end
  end

  // Falling-edge register.
  always_ff @(negedge i_tck) begin
    fr_r <= fr_nxt;
  end

  // System-clock logic: pin output multiplexer.
  always_comb begin
    sr_nxt = sr_r;
    sr_nxt.ext_s1 = (rr_r.instr == INS_EXTEST);
    sr_nxt.ext_s2 = sr_r.ext_s1;
    sr_nxt.tgl_s1 = fr_r.upd_tgl;
    sr_nxt.tgl_s2 = sr_r.tgl_s1;
    sr_nxt.tgl_s3 = sr_r.tgl_s2;
    // The latch changes with its toggle and then stays stable for many test clocks, so it is
    // taken whole once the toggle has crossed; no bit can be caught mid-change.
    if (sr_r.tgl_s2 != sr_r.tgl_s3) begin
      sr_nxt.shadow = fr_r.upd;
    end
    // Normal path unless external test is in force.
    sr_nxt.pin_out = sr_r.ext_s2 ? sr_r.shadow : i_core_out;
    if (i_reset) begin
      sr_nxt = '0;
    end
  end

  // System-clock register.
  always_ff @(posedge i_clk) begin
    sr_r <= sr_nxt;
  end

  assign o_tdo = fr_r.tdo;
  assign o_tdo_oe = fr_r.tdo_oe;
  assign o_pin_out = sr_r.pin_out;

  // Checks on the test-clock side.
  default clocking cb @(posedge i_tck);
  endclocking
  // The raw reset covers the edges before the synchroniser holds a known level.
  default disable iff (i_reset || rr_r.rst_s2);

  a_tms_reset_entry: assert property (i_tms [*5] |=> rr_r.st == ST_TLR)
    else $error("Five high mode-select edges did not reach reset state.");
  a_reset_ident_load: assert property (rr_r.st == ST_TLR |=> rr_r.instr == INS_IDCODE)
    else $error("Reset state did not load the identification instruction.");
  a_ir_lsb_first: assert property (rr_r.st == ST_SH_IR |=>
      rr_r.ir_sh[IR_W-1] == $past(i_tdi) && rr_r.ir_sh[IR_W-2:0] == $past(rr_r.ir_sh[IR_W-1:1]))
    else $error("Instruction shifter did not shift toward bit 0.");
  a_instr_stable: assert property ($changed(rr_r.instr) |->
      $past(rr_r.st) inside {ST_UPD_IR, ST_TLR} || $past(rr_r.rst_s2))
    else $error("Instruction changed outside Update-IR or reset.");
  a_bypass_delay: assert property (rr_r.st == ST_SH_DR && rr_r.instr == INS_BYPASS
      ##1 rr_r.st == ST_SH_DR |-> o_tdo == $past(i_tdi) && o_tdo_oe)
    else $error("Bypass path did not give one test-clock delay.");
  a_ident_capture: assert property (rr_r.st == ST_CAP_DR && rr_r.instr == INS_IDCODE
      |=> rr_r.id_sh == ID_VALUE && rr_r.id_sh[0])
    else $error("Identification word not captured.");
  a_ident_shift: assert property (rr_r.st == ST_SH_DR && rr_r.instr == INS_IDCODE
      |=> rr_r.id_sh[ID_W-2:0] == $past(rr_r.id_sh[ID_W-1:1]))
    else $error("Identification word not shifted LSB first.");
  a_chain_capture: assert property (rr_r.st == ST_CAP_DR && bsr_sel(rr_r.instr)
      |=> rr_r.pin_scan_chain == $past(rr_r.pin_s2))
    else $error("Pin chain did not capture the pins.");
  a_chain_shift: assert property (rr_r.st == ST_SH_DR && bsr_sel(rr_r.instr)
      |=> rr_r.pin_scan_chain[BSR_LEN-1] == $past(i_tdi))
    else $error("Pin chain did not take serial input.");
  a_chain_hold: assert property (!bsr_sel(rr_r.instr) |=> $stable(rr_r.pin_scan_chain))
    else $error("Pin chain moved under another instruction.");
  a_tdo_drive: assert property (o_tdo_oe == (rr_r.st inside {ST_SH_DR, ST_SH_IR}))
    else $error("Serial output enable outside shift states.");
  a_latch_update: assert property ($changed(fr_r.upd) |-> rr_r.st == ST_UPD_DR)
    else $error("Pin latch changed outside Update-DR.");

  c_ident_read: cover property (rr_r.st == ST_SH_DR && rr_r.instr == INS_IDCODE);
  c_extest_update: cover property (rr_r.st == ST_UPD_DR && rr_r.instr == INS_EXTEST);
  c_bypass_shift: cover property (rr_r.st == ST_SH_DR && rr_r.instr == INS_BYPASS);
  c_tms_reset: cover property (rr_r.st == ST_SH_DR ##1 i_tms [*5]);

endmodule  // bst_port

/* verif/bst_tester.sv */
// Tester model that clocks the test port and walks its controller.
`timescale 1ns/1ps
module bst_tester (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  // Half of the 160 ns test-clock period.
  localparam time HALF = 80;
  // The test clock stands low between periods, so it only runs inside frames.
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One test-clock period; levels change while the clock is low.
  task automatic step(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    #HALF o_tck = 1'b1;
    #HALF o_tck = 1'b0;
  endtask
  // Five high mode-select periods reach Test-Logic-Reset from any state.
  task automatic reset_walk();
    repeat (5) step(1'b1, 1'b0);
  endtask
  // From Run-Test/Idle, scans n bits LSB first and returns to Run-Test/Idle.
  task automatic scan(input logic ir, input int n, input logic [127:0] din);
    step(1'b1, 1'b0);
    if (ir) begin
      step(1'b1, 1'b0);
    end
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k]);
    end
    // Data is no longer taken here, so the inverse of the last bit is shown.
    step(1'b1, ~din[n-1]);
    step(1'b0, ~din[n-1]);
  endtask
endmodule // bst_tester

/* verif/testbench.sv */
// Self-checking testbench of the boundary-scan test port.
`timescale 1ns/1ps
module testbench import bst_pkg::*;;
  logic i_clk;
  logic i_reset;
  logic tck;
  logic tms;
  logic tdi;
  logic [BSR_IN_W-1:0] i_pin_in;
  logic [BSR_OUT_W-1:0] i_core_out;
  logic o_tdo;
  logic o_tdo_oe;
  logic [BSR_OUT_W-1:0] o_pin_out;
  int err_count = 0;
  int check_count = 0;
  int seed = 32'ha0f0dae6;
  logic exp_q[$]; // Serial bits still expected, oldest first.
  logic [BSR_LEN-1:0] pat;
  logic [BSR_LEN-1:0] pat2;
  logic [31:0] d;
  logic [IR_W-1:0] codes [2] = '{INS_BYPASS, 3'h5};
  // Arbitrary identity values, distinct from the design defaults.
  localparam logic [ID_W-1:0] ID_EXP = {4'h9, 16'hB7E1, 11'h3C5, 1'b1};

  bst_port #(.PRODUCER(11'h3C5), .PART(16'hB7E1), .REVISION(4'h9)) i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_pin_in(i_pin_in), .i_core_out(i_core_out), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe), .o_pin_out(o_pin_out));
  bst_tester i_tst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic cmp(input string name, input logic [BSR_LEN-1:0] exp,
                     input logic [BSR_LEN-1:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d.", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  // Notes the bits expected on the serial output, first bit first.
  task automatic expect_bits(input int n, input logic [127:0] v);
    for (int k = 0; k < n; k++) exp_q.push_back(v[k]);
  endtask
  // Loads an instruction; the shifter shows its capture pattern meanwhile.
  task automatic load_ir(input logic [IR_W-1:0] code);
    expect_bits(IR_W, IR_CAPT_VAL);
    i_tst.scan(1'b1, IR_W, code);
  endtask
  // The pins cross into the system clock in a few cycles; eight is ample.
  task automatic check_pins(input logic [BSR_OUT_W-1:0] exp);
    repeat (8) @(negedge i_clk);
    cmp("pins", exp, o_pin_out);
  endtask

  // Every falling edge with the output enabled yields one serial result.
  always @(negedge tck) begin
    #1;
    if (o_tdo_oe === 1'b1) begin
      if (exp_q.size() == 0) cmp("tdo extra", 1'b0, 1'b1);
      else cmp("tdo", exp_q.pop_front(), o_tdo);
    end
  end

  // A hang ends the run as a mismatch.
  initial begin
    #400000;
    cmp("timeout", 1'b0, 1'b1);
    conclude();
  end

  initial begin
    i_reset = 1'b1;
    i_pin_in = '0;
    i_core_out = '0;
    // Reset stays up past eight cycles so the test side sees it too.
    repeat (8) @(negedge i_clk);
    repeat (4) i_tst.step(1'b1, 1'b0);
    @(negedge i_clk);
    i_reset = 1'b0;
    i_core_out = rnd();
    i_tst.reset_walk();
    i_tst.step(1'b0, 1'b0);
    check_pins(i_core_out);
    expect_bits(ID_W, ID_EXP);
    i_tst.scan(1'b0, ID_W, rnd());
    // Bypass and an undefined code both give a one-period serial delay.
    foreach (codes[i]) begin
      load_ir(codes[i]);
      d = $random(seed);
      expect_bits(32, {d[30:0], 1'b0});
      i_tst.scan(1'b0, 32, d);
    end
    @(negedge i_clk);
    i_pin_in = rnd();
    load_ir(INS_SAMPLE);
    check_pins(i_core_out);
    pat = rnd();
    expect_bits(BSR_LEN, {i_core_out, i_pin_in});
    i_tst.scan(1'b0, BSR_LEN, pat);
    check_pins(i_core_out);
    load_ir(INS_EXTEST);
    check_pins(pat[BSR_LEN-1:BSR_IN_W]);
    @(negedge i_clk);
    i_pin_in = rnd();
    pat2 = rnd();
    expect_bits(BSR_LEN, {pat[BSR_LEN-1:BSR_IN_W], i_pin_in});
    i_tst.scan(1'b0, BSR_LEN, pat2);
    check_pins(pat2[BSR_LEN-1:BSR_IN_W]);
    // Abort in mid-shift: the first high mode-select leaves after one bit.
    i_tst.step(1'b1, 1'b0);
    i_tst.step(1'b0, 1'b0);
    i_tst.step(1'b0, 1'b0);
    expect_bits(1, i_pin_in[0]);
    i_tst.reset_walk();
    i_tst.step(1'b0, 1'b0);
    check_pins(i_core_out);
    expect_bits(ID_W, ID_EXP);
    i_tst.scan(1'b0, ID_W, rnd());
    cmp("left", '0, exp_q.size());
    conclude();
  end
endmodule // testbench
